// ===== design/cit_consts.svh
// constants for the instruction timing decoder: bytes and cycles per form
`ifndef CIT_CONSTS_SVH
`define CIT_CONSTS_SVH

// ****************************************
// timing pairs, packed as {bytes[1:0], cycles[2:0]}
// ****************************************
`define CIT_T_MOV_A_REG       {2'h1, 3'h1}
`define CIT_T_MOV_A_DIR       {2'h2, 3'h2}
`define CIT_T_MOV_A_IND       {2'h1, 3'h2}
`define CIT_T_MOV_A_IMM       {2'h2, 3'h2}
`define CIT_T_MOV_REG_A       {2'h1, 3'h2}
`define CIT_T_MOV_REG_DIR     {2'h2, 3'h4}
`define CIT_T_MOV_REG_IMM     {2'h2, 3'h2}
`define CIT_T_MOV_DIR_A       {2'h2, 3'h3}
`define CIT_T_MOV_DIR_REG     {2'h2, 3'h3}
`define CIT_T_MOV_DIR_DIR     {2'h3, 3'h4}
`define CIT_T_MOV_DIR_IND     {2'h2, 3'h4}
`define CIT_T_MOV_DIR_IMM     {2'h3, 3'h3}
`define CIT_T_MOV_IND_A       {2'h1, 3'h3}
`define CIT_T_MOV_IND_DIR     {2'h2, 3'h3}
`define CIT_T_MOV_IND_IMM     {2'h2, 3'h3}
`define CIT_T_LOAD_DP         {2'h3, 3'h3}
`define CIT_T_CODE_READ       {2'h1, 3'h4}
`define CIT_T_AUX_MOVE        {2'h1, 3'h3}
`define CIT_T_PUSH            {2'h2, 3'h4}
`define CIT_T_POP             {2'h2, 3'h3}
`define CIT_T_XCH_REG         {2'h1, 3'h3}
`define CIT_T_XCH_DIR         {2'h2, 3'h4}
`define CIT_T_XCH_IND         {2'h1, 3'h4}
`define CIT_T_LOW_DIGIT_XCH   {2'h1, 3'h4}
`define CIT_T_ALU_REG         {2'h1, 3'h2}
`define CIT_T_ALU_DIR         {2'h2, 3'h3}
`define CIT_T_ALU_IND         {2'h1, 3'h3}
`define CIT_T_ALU_IMM         {2'h2, 3'h2}
`define CIT_T_INCDEC_A        {2'h1, 3'h2}
`define CIT_T_INCDEC_REG      {2'h1, 3'h3}
`define CIT_T_INCDEC_DIR      {2'h2, 3'h4}
`define CIT_T_INCDEC_IND      {2'h1, 3'h4}
`define CIT_T_INC_DP          {2'h1, 3'h1}
`define CIT_T_MUL             {2'h1, 3'h4}
`define CIT_T_DIV             {2'h1, 3'h5}
`define CIT_T_DEC_ADJ         {2'h1, 3'h4}
`define CIT_T_LOGIC_DIR_A     {2'h2, 3'h4}
`define CIT_T_LOGIC_DIR_IMM   {2'h3, 3'h4}
`define CIT_T_CLR_A           {2'h1, 3'h1}
`define CIT_T_CPL_A           {2'h1, 3'h2}
`define CIT_T_ROT_SWAP        {2'h1, 3'h1}
`define CIT_T_CARRY_OP        {2'h1, 3'h1}
`define CIT_T_BIT_OP          {2'h2, 3'h4}
`define CIT_T_BIT_TO_CARRY    {2'h2, 3'h3}
`define CIT_T_CARRY_TO_BIT    {2'h2, 3'h4}
`define CIT_T_JMP_FLAG        {2'h2, 3'h3}
`define CIT_T_JMP_BIT         {2'h3, 3'h4}
`define CIT_T_BIT_TEST_CLR    {2'h3, 3'h5}
`define CIT_T_CALL_ABS        {2'h2, 3'h6}
`define CIT_T_CALL_LONG       {2'h3, 3'h6}
`define CIT_T_RETURN          {2'h1, 3'h4}
`define CIT_T_JMP_ABS         {2'h2, 3'h3}
`define CIT_T_JMP_LONG        {2'h3, 3'h4}
`define CIT_T_JMP_SHORT       {2'h2, 3'h3}
`define CIT_T_JMP_IND         {2'h1, 3'h3}
`define CIT_T_CMP_MEM         {2'h3, 3'h5}
`define CIT_T_CMP_IMM         {2'h3, 3'h4}
`define CIT_T_DEC_BR_REG      {2'h2, 3'h4}
`define CIT_T_DEC_BR_DIR      {2'h3, 3'h5}
`define CIT_T_NOP             {2'h1, 3'h1}

// ****************************************
// misc
// ****************************************
`define CIT_T_NONE            {2'h1, 3'h0}
`define CIT_FETCH_RESET       16'h0000

`endif

// ===== design/cit_cycle_seq.sv
// down-counter of execution cycles left in the current instruction
`timescale 1ns/1ps
`default_nettype none
module cit_cycle_seq (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   cit_seq_if.seq    sq
);

   // ****************************************
   // count
   // ****************************************
   // one count per clock edge, no multi-clock machine cycle
   always_comb begin
      if (sq.load) begin
         sq.rem_nxt = sq.load_cycles;
      end else if (sq.rem_r != 3'h0) begin
         sq.rem_nxt = sq.rem_r - 3'h1; // [RQ19]
      end else begin
         sq.rem_nxt = 3'h0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sq.rem_r <= 3'h0;
      end else begin
         sq.rem_r <= sq.rem_nxt;
      end
   end

endmodule
`default_nettype wire

// ===== design/cit_pkg.sv
// types shared by the instruction timing decoder
package cit_pkg;

   // instruction forms; alu_* covers add, add-carry, sub-borrow, and, or, xor into acc
   typedef enum logic [5:0] {
      F_MOV_A_REG = 6'h00, F_MOV_A_DIR = 6'h01, F_MOV_A_IND = 6'h02, F_MOV_A_IMM = 6'h03,
      F_MOV_REG_A = 6'h04, F_MOV_REG_DIR = 6'h05, F_MOV_REG_IMM = 6'h06,
      F_MOV_DIR_A = 6'h07, F_MOV_DIR_REG = 6'h08, F_MOV_DIR_DIR = 6'h09,
      F_MOV_DIR_IND = 6'h0a, F_MOV_DIR_IMM = 6'h0b, F_MOV_IND_A = 6'h0c,
      F_MOV_IND_DIR = 6'h0d, F_MOV_IND_IMM = 6'h0e, F_LOAD_DP = 6'h0f,
      F_CODE_READ = 6'h10, F_AUX_MOVE = 6'h11, F_PUSH = 6'h12, F_POP = 6'h13,
      F_XCH_REG = 6'h14, F_XCH_DIR = 6'h15, F_XCH_IND = 6'h16, F_LOW_DIGIT_XCH = 6'h17,
      F_ALU_REG = 6'h18, F_ALU_DIR = 6'h19, F_ALU_IND = 6'h1a, F_ALU_IMM = 6'h1b,
      F_INCDEC_A = 6'h1c, F_INCDEC_REG = 6'h1d, F_INCDEC_DIR = 6'h1e,
      F_INCDEC_IND = 6'h1f, F_INC_DP = 6'h20, F_MUL = 6'h21, F_DIV = 6'h22,
      F_DEC_ADJ = 6'h23, F_LOGIC_DIR_A = 6'h24, F_LOGIC_DIR_IMM = 6'h25,
      F_CLR_A = 6'h26, F_CPL_A = 6'h27, F_ROT_SWAP = 6'h28, F_CARRY_OP = 6'h29,
      F_BIT_OP = 6'h2a, F_BIT_TO_CARRY = 6'h2b, F_CARRY_TO_BIT = 6'h2c,
      F_JMP_FLAG = 6'h2d, F_JMP_BIT = 6'h2e, F_BIT_TEST_CLR = 6'h2f,
      F_CALL_ABS = 6'h30, F_CALL_LONG = 6'h31, F_RETURN = 6'h32, F_JMP_ABS = 6'h33,
      F_JMP_LONG = 6'h34, F_JMP_SHORT = 6'h35, F_JMP_IND = 6'h36, F_CMP_MEM = 6'h37,
      F_CMP_IMM = 6'h38, F_DEC_BR_REG = 6'h39, F_DEC_BR_DIR = 6'h3a, F_NOP = 6'h3b
   } cit_form_e;

   typedef struct packed {
      logic [1:0] len;
      logic [2:0] cyc;
   } cit_timing_s;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_EXEC  = 3'h2,
      ST_FAULT = 3'h4
   } cit_state_e;

endpackage

// ===== design/cit_seq_if.sv
// carrier between the timing decoder and its cycle sequencer
`timescale 1ns/1ps
`default_nettype none
interface cit_seq_if;
   logic       load;
   logic [2:0] load_cycles;
   logic [2:0] rem_r;
   logic [2:0] rem_nxt;

   modport ctrl (output load, output load_cycles, input rem_r, input rem_nxt);
   modport seq  (input load, input load_cycles, output rem_r, output rem_nxt);
endinterface
`default_nettype wire

// ===== design/cit_top.sv
// instruction length and execution-cycle timing decoder of the one-clock core
//
// Contract
// RQ1: external ram moves unsupported; aux ram only
// RQ2: aux ram moves: one byte, three cycles
// RQ3: reg to acc 1/1; acc to reg 1/2
// RQ4: code byte read: one byte, four cycles
// RQ5: data_pointer constant load: three bytes, three cycles
// RQ6: direct to direct move: three bytes, four cycles
// RQ7: add/addc/subb: reg,imm two; dir,ind three cycles
// RQ8: logic to direct: four cycles; 2 or 3 bytes
// RQ9: rotates, swap, clear one cycle; complement two
// RQ10: push 2/4, pop 2/3
// RQ11: exchange reg three; direct/indirect/low digit four
// RQ12: bit into carry 2/3; carry into bit four
// RQ13: carry or acc branches: two bytes, three cycles
// RQ14: bit branches 3/4; test-and-clear five cycles
// RQ15: calls six cycles; returns one byte, four
// RQ16: jumps 2/3, long 3/4, indirect 1/3
// RQ17: compare branch: memory five, immediate four cycles
// RQ18: decrement branch: reg 2/4, direct 3/5
// RQ19: cycles are system clocks, one per edge
`timescale 1ns/1ps
`default_nettype none
`include "cit_consts.svh"
module cit_top (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              instr_valid,
   input  wire cit_pkg::cit_form_e instr_form,
   input  wire logic              ext_ram_sel,
   input  wire logic              branch_taken,
   input  wire logic [15:0]       branch_target,
   output logic                   issue_ready_r,
   output logic                   exec_busy_r,
   output logic                   retire_r,
   output logic                   fault_r,
   output logic [1:0]             instr_len_r,
   output logic [2:0]             exec_cycles_r,
   output logic [15:0]            fetch_addr_r
);

   // ****************************************
   // decode
   // ****************************************
   cit_pkg::cit_timing_s timing;
   logic                 supported;
   logic                 accept;
   cit_pkg::cit_state_e  state_r;
   cit_pkg::cit_state_e  state_nxt;

   cit_seq_if seq_bus ();

   always_comb begin
      timing    = `CIT_T_NONE;
      supported = 1'b1;
      case (instr_form)
         cit_pkg::F_MOV_A_REG:     timing = `CIT_T_MOV_A_REG;     // [RQ3]
         cit_pkg::F_MOV_A_DIR:     timing = `CIT_T_MOV_A_DIR;
         cit_pkg::F_MOV_A_IND:     timing = `CIT_T_MOV_A_IND;
         cit_pkg::F_MOV_A_IMM:     timing = `CIT_T_MOV_A_IMM;
         cit_pkg::F_MOV_REG_A:     timing = `CIT_T_MOV_REG_A;     // [RQ3]
         cit_pkg::F_MOV_REG_DIR:   timing = `CIT_T_MOV_REG_DIR;
         cit_pkg::F_MOV_REG_IMM:   timing = `CIT_T_MOV_REG_IMM;
         cit_pkg::F_MOV_DIR_A:     timing = `CIT_T_MOV_DIR_A;
         cit_pkg::F_MOV_DIR_REG:   timing = `CIT_T_MOV_DIR_REG;
         cit_pkg::F_MOV_DIR_DIR:   timing = `CIT_T_MOV_DIR_DIR;   // [RQ6]
         cit_pkg::F_MOV_DIR_IND:   timing = `CIT_T_MOV_DIR_IND;
         cit_pkg::F_MOV_DIR_IMM:   timing = `CIT_T_MOV_DIR_IMM;
         cit_pkg::F_MOV_IND_A:     timing = `CIT_T_MOV_IND_A;
         cit_pkg::F_MOV_IND_DIR:   timing = `CIT_T_MOV_IND_DIR;
         cit_pkg::F_MOV_IND_IMM:   timing = `CIT_T_MOV_IND_IMM;
         cit_pkg::F_LOAD_DP:       timing = `CIT_T_LOAD_DP;       // [RQ5]
         cit_pkg::F_CODE_READ:     timing = `CIT_T_CODE_READ;     // [RQ4]
         cit_pkg::F_AUX_MOVE: begin
            // only the on-chip aux ram answers; an external target has no bus
            if (ext_ram_sel) begin
               timing    = `CIT_T_NONE;                          // [RQ1]
               supported = 1'b0;
            end else begin
               timing = `CIT_T_AUX_MOVE;                         // [RQ2]
            end
         end
         cit_pkg::F_PUSH:          timing = `CIT_T_PUSH;          // [RQ10]
         cit_pkg::F_POP:           timing = `CIT_T_POP;           // [RQ10]
         cit_pkg::F_XCH_REG:       timing = `CIT_T_XCH_REG;       // [RQ11]
         cit_pkg::F_XCH_DIR:       timing = `CIT_T_XCH_DIR;       // [RQ11]
         cit_pkg::F_XCH_IND:       timing = `CIT_T_XCH_IND;       // [RQ11]
         cit_pkg::F_LOW_DIGIT_XCH: timing = `CIT_T_LOW_DIGIT_XCH; // [RQ11]
         cit_pkg::F_ALU_REG:       timing = `CIT_T_ALU_REG;       // [RQ7]
         cit_pkg::F_ALU_DIR:       timing = `CIT_T_ALU_DIR;       // [RQ7]
         cit_pkg::F_ALU_IND:       timing = `CIT_T_ALU_IND;       // [RQ7]
         cit_pkg::F_ALU_IMM:       timing = `CIT_T_ALU_IMM;       // [RQ7]
         cit_pkg::F_INCDEC_A:      timing = `CIT_T_INCDEC_A;
         cit_pkg::F_INCDEC_REG:    timing = `CIT_T_INCDEC_REG;
         cit_pkg::F_INCDEC_DIR:    timing = `CIT_T_INCDEC_DIR;
         cit_pkg::F_INCDEC_IND:    timing = `CIT_T_INCDEC_IND;
         cit_pkg::F_INC_DP:        timing = `CIT_T_INC_DP;
         cit_pkg::F_MUL:           timing = `CIT_T_MUL;
         cit_pkg::F_DIV:           timing = `CIT_T_DIV;
         cit_pkg::F_DEC_ADJ:       timing = `CIT_T_DEC_ADJ;
         cit_pkg::F_LOGIC_DIR_A:   timing = `CIT_T_LOGIC_DIR_A;   // [RQ8]
         cit_pkg::F_LOGIC_DIR_IMM: timing = `CIT_T_LOGIC_DIR_IMM; // [RQ8]
         cit_pkg::F_CLR_A:         timing = `CIT_T_CLR_A;         // [RQ9]
         cit_pkg::F_CPL_A:         timing = `CIT_T_CPL_A;         // [RQ9]
         cit_pkg::F_ROT_SWAP:      timing = `CIT_T_ROT_SWAP;      // [RQ9]
         cit_pkg::F_CARRY_OP:      timing = `CIT_T_CARRY_OP;
         cit_pkg::F_BIT_OP:        timing = `CIT_T_BIT_OP;
         cit_pkg::F_BIT_TO_CARRY:  timing = `CIT_T_BIT_TO_CARRY;  // [RQ12]
         cit_pkg::F_CARRY_TO_BIT:  timing = `CIT_T_CARRY_TO_BIT;  // [RQ12]
         cit_pkg::F_JMP_FLAG:      timing = `CIT_T_JMP_FLAG;      // [RQ13]
         cit_pkg::F_JMP_BIT:       timing = `CIT_T_JMP_BIT;       // [RQ14]
         cit_pkg::F_BIT_TEST_CLR:  timing = `CIT_T_BIT_TEST_CLR;  // [RQ14]
         cit_pkg::F_CALL_ABS:      timing = `CIT_T_CALL_ABS;      // [RQ15]
         cit_pkg::F_CALL_LONG:     timing = `CIT_T_CALL_LONG;     // [RQ15]
         cit_pkg::F_RETURN:        timing = `CIT_T_RETURN;        // [RQ15]
         cit_pkg::F_JMP_ABS:       timing = `CIT_T_JMP_ABS;       // [RQ16]
         cit_pkg::F_JMP_LONG:      timing = `CIT_T_JMP_LONG;      // [RQ16]
         cit_pkg::F_JMP_SHORT:     timing = `CIT_T_JMP_SHORT;     // [RQ16]
         cit_pkg::F_JMP_IND:       timing = `CIT_T_JMP_IND;       // [RQ16]
         cit_pkg::F_CMP_MEM:       timing = `CIT_T_CMP_MEM;       // [RQ17]
         cit_pkg::F_CMP_IMM:       timing = `CIT_T_CMP_IMM;       // [RQ17]
         cit_pkg::F_DEC_BR_REG:    timing = `CIT_T_DEC_BR_REG;    // [RQ18]
         cit_pkg::F_DEC_BR_DIR:    timing = `CIT_T_DEC_BR_DIR;    // [RQ18]
         cit_pkg::F_NOP:           timing = `CIT_T_NOP;
         default: begin
            // unused form codes are refused like an external move
            timing    = `CIT_T_NONE;
            supported = 1'b0;
         end
      endcase
   end

   // ****************************************
   // issue and sequencing
   // ****************************************
   // issue is open in the last cycle too, so instructions run back to back
   assign accept              = instr_valid && issue_ready_r;
   assign seq_bus.load        = accept && supported;
   assign seq_bus.load_cycles = timing.cyc;

   cit_cycle_seq u_seq (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .sq      (seq_bus.seq)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cit_pkg::ST_IDLE, cit_pkg::ST_EXEC, cit_pkg::ST_FAULT: begin
            if (accept && !supported) begin
               state_nxt = cit_pkg::ST_FAULT;                   // [RQ1]
            end else if (seq_bus.rem_nxt != 3'h0) begin
               state_nxt = cit_pkg::ST_EXEC;                    // [RQ19]
            end else begin
               state_nxt = cit_pkg::ST_IDLE;
            end
         end
         default: state_nxt = cit_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= cit_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************
   // status outputs; ready, busy and retire registered from next-state terms
   // ****************************************
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         issue_ready_r <= 1'b1;
         exec_busy_r   <= 1'b0;
         retire_r      <= 1'b0;
      end else begin
         issue_ready_r <= (seq_bus.rem_nxt <= 3'h1);             // [RQ19]
         exec_busy_r   <= (seq_bus.rem_nxt != 3'h0);
         retire_r      <= (seq_bus.rem_nxt == 3'h1);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_r <= 1'b0;
      end else begin
         fault_r <= accept && !supported;                       // [RQ1]
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         instr_len_r   <= 2'h0;
         exec_cycles_r <= 3'h0;
      end else if (accept) begin
         instr_len_r   <= timing.len;
         exec_cycles_r <= timing.cyc;
      end
   end

   // ****************************************
   // fetch address
   // ****************************************
   // refused moves still step over their one byte so fetch does not stall
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fetch_addr_r <= `CIT_FETCH_RESET;
      end else if (accept) begin
         if (branch_taken && supported) begin
            fetch_addr_r <= branch_target;
         end else begin
            fetch_addr_r <= fetch_addr_r + {14'h0000, timing.len};
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/cit_code_src.sv
// program memory side: offers one instruction form and holds it until taken
`timescale 1ns/1ps
`default_nettype none
module cit_code_src (
   input  wire logic               sys_clk,
   input  wire logic               reset_n,
   input  wire logic               req,
   input  wire cit_pkg::cit_form_e req_form,
   input  wire logic               req_ext,
   input  wire logic               req_br,
   input  wire logic [15:0]        req_tgt,
   input  wire logic               issue_ready_r,
   output logic                    instr_valid,
   output var cit_pkg::cit_form_e  instr_form,
   output logic                    ext_ram_sel,
   output logic                    branch_taken,
   output logic [15:0]             branch_target
);
   // ****************************************
   // offer register
   // ****************************************
   // idle lines flip every cycle so a stale form can never pass for a live one
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         instr_valid   <= 1'b0;
         instr_form    <= cit_pkg::F_NOP;
         ext_ram_sel   <= 1'b0;
         branch_taken  <= 1'b0;
         branch_target <= 16'h0000;
      end else if (req) begin
         instr_valid   <= 1'b1;
         instr_form    <= req_form;
         ext_ram_sel   <= req_ext;
         branch_taken  <= req_br;
         branch_target <= req_tgt;
      end else if (!instr_valid || issue_ready_r) begin
         instr_valid   <= 1'b0;
         instr_form    <= cit_pkg::cit_form_e'(~instr_form);
         ext_ram_sel   <= ~ext_ram_sel;
         branch_taken  <= ~branch_taken;
         branch_target <= ~branch_target;
      end
   end
endmodule
`default_nettype wire

// ===== tb/cit_top_checker.sv
// port timing assertions for the instruction timing decoder
`timescale 1ns/1ps
`default_nettype none
module cit_top_checker (
   input  wire logic               sys_clk,
   input  wire logic               reset_n,
   input  wire logic               instr_valid,
   input  wire cit_pkg::cit_form_e instr_form,
   input  wire logic               ext_ram_sel,
   input  wire logic               branch_taken,
   input  wire logic [15:0]        branch_target,
   input  wire logic               issue_ready_r,
   input  wire logic               exec_busy_r,
   input  wire logic               retire_r,
   input  wire logic               fault_r,
   input  wire logic [1:0]         instr_len_r,
   input  wire logic [2:0]         exec_cycles_r,
   input  wire logic [15:0]        fetch_addr_r
);
   logic take;
   assign take = instr_valid && issue_ready_r;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // ****************************************
   // assertions
   // ****************************************
   a_ext_ram_refused: assert property (take && instr_form == cit_pkg::F_AUX_MOVE
      && ext_ram_sel |=> fault_r && !exec_busy_r && exec_cycles_r == 3'h0)
      else $error("external ram move was executed");
   a_aux_move_time: assert property (take && instr_form == cit_pkg::F_AUX_MOVE
      && !ext_ram_sel |=> instr_len_r == 2'h1 && exec_cycles_r == 3'h3
      ##0 !retire_r ##1 !retire_r ##1 retire_r) else $error("aux ram move timing wrong");
   a_reg_copy_one: assert property (take && instr_form == cit_pkg::F_MOV_A_REG
      |=> retire_r && exec_busy_r && instr_len_r == 2'h1) else $error("register copy not 1/1");
   a_code_read_four: assert property (take && instr_form == cit_pkg::F_CODE_READ
      |=> (exec_busy_r && !retire_r)[*3] ##1 retire_r) else $error("code read not four");
   a_dp_load_len: assert property (take && instr_form == cit_pkg::F_LOAD_DP
      |=> instr_len_r == 2'h3 && exec_cycles_r == 3'h3) else $error("pointer load not 3/3");
   a_rotate_one: assert property (take && instr_form == cit_pkg::F_ROT_SWAP
      |=> retire_r && exec_cycles_r == 3'h1) else $error("rotate not one cycle");
   a_call_six: assert property (take && (instr_form == cit_pkg::F_CALL_ABS
      || instr_form == cit_pkg::F_CALL_LONG) |=> (!retire_r)[*5] ##1 retire_r)
      else $error("call not six cycles");
   a_branch_load: assert property (take && branch_taken
      && instr_form == cit_pkg::F_JMP_LONG |=> fetch_addr_r == $past(branch_target)
      && instr_len_r == 2'h3 && exec_cycles_r == 3'h4) else $error("long jump fetch wrong");
   a_busy_blocks: assert property (exec_busy_r && !retire_r |-> !issue_ready_r)
      else $error("offer accepted mid instruction");
   a_retire_ready: assert property (retire_r |-> issue_ready_r && exec_busy_r)
      else $error("retire outside a busy cycle");
   c_aux_take: cover property (take && instr_form == cit_pkg::F_AUX_MOVE && !ext_ram_sel);
   c_fault_seen: cover property (fault_r);
   c_branch_take: cover property (take && branch_taken);
endmodule
bind cit_top cit_top_checker u_cit_top_checker (
   .sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
   .instr_form(instr_form), .ext_ram_sel(ext_ram_sel), .branch_taken(branch_taken),
   .branch_target(branch_target), .issue_ready_r(issue_ready_r),
   .exec_busy_r(exec_busy_r), .retire_r(retire_r), .fault_r(fault_r),
   .instr_len_r(instr_len_r), .exec_cycles_r(exec_cycles_r), .fetch_addr_r(fetch_addr_r));
`default_nettype wire

// ===== tb/cit_top_tb.sv
// self-checking bench for the instruction timing decoder
`timescale 1ns/1ps
`default_nettype none
module cit_top_tb;
   logic               sys_clk, reset_n, req, req_ext, req_br;
   logic               instr_valid, ext_ram_sel, branch_taken;
   logic               issue_ready_r, exec_busy_r, retire_r, fault_r;
   logic [1:0]         instr_len_r;
   logic [2:0]         exec_cycles_r;
   logic [15:0]        req_tgt, branch_target, fetch_addr_r, exp_fa;
   cit_pkg::cit_form_e req_form, instr_form;
   int                 n_errors, n_compared;

   cit_top u_cit_top (.sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr_form(instr_form), .ext_ram_sel(ext_ram_sel), .branch_taken(branch_taken),
      .branch_target(branch_target), .issue_ready_r(issue_ready_r),
      .exec_busy_r(exec_busy_r), .retire_r(retire_r), .fault_r(fault_r),
      .instr_len_r(instr_len_r), .exec_cycles_r(exec_cycles_r), .fetch_addr_r(fetch_addr_r));
   cit_code_src u_cit_code_src (.sys_clk(sys_clk), .reset_n(reset_n), .req(req),
      .req_form(req_form), .req_ext(req_ext), .req_br(req_br), .req_tgt(req_tgt),
      .issue_ready_r(issue_ready_r), .instr_valid(instr_valid), .instr_form(instr_form),
      .ext_ram_sel(ext_ram_sel), .branch_taken(branch_taken), .branch_target(branch_target));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // offer one form, judge length, cycles, fetch and busy run
   task automatic go(input cit_pkg::cit_form_e f, input logic x, input logic b,
                     input logic [15:0] tg, input logic [1:0] el, input logic [2:0] ec);
      int k;
      @(posedge sys_clk);
      req      <= 1'b1;
      req_form <= f;
      req_ext  <= x;
      req_br   <= b;
      req_tgt  <= tg;
      @(posedge sys_clk);
      req <= 1'b0;
      #1;
      k = 0;
      while (!(instr_valid === 1'b1 && issue_ready_r === 1'b1) && k < 20) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      if (k == 20) begin
         n_errors++;
         stop_test();
      end
      @(posedge sys_clk);
      #1;
      exp_fa = (b && ec != 3'h0) ? tg : exp_fa + 16'(el);
      chk(16'(instr_len_r), 16'(el));
      chk(16'(exec_cycles_r), 16'(ec));
      chk(fetch_addr_r, exp_fa);
      chk(16'(fault_r), 16'(ec == 3'h0));
      k = 0;
      // a refused form must leave the core idle
      while (ec != 3'h0 && retire_r !== 1'b1 && k < 8) begin
         chk(16'(exec_busy_r), 16'h0001);
         @(posedge sys_clk);
         #1;
         k++;
      end
      chk(16'(ec == 3'h0 ? exec_busy_r : retire_r), 16'(ec != 3'h0));
      if (ec != 3'h0) chk(16'(k + 1), 16'(ec));
   endtask

   task automatic run(input cit_pkg::cit_form_e f, input logic [1:0] el, input logic [2:0] ec);
      go(f, 1'b0, 1'b0, 16'h0000, el, ec);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_moves();
      run(cit_pkg::F_AUX_MOVE, 2'h1, 3'h3);
      run(cit_pkg::F_MOV_A_REG, 2'h1, 3'h1);
      run(cit_pkg::F_MOV_REG_A, 2'h1, 3'h2);
      run(cit_pkg::F_CODE_READ, 2'h1, 3'h4);
      run(cit_pkg::F_LOAD_DP, 2'h3, 3'h3);
      run(cit_pkg::F_MOV_DIR_DIR, 2'h3, 3'h4);
      run(cit_pkg::F_MOV_A_DIR, 2'h2, 3'h2);
      run(cit_pkg::F_MOV_A_IND, 2'h1, 3'h2);
      run(cit_pkg::F_MOV_A_IMM, 2'h2, 3'h2);
      run(cit_pkg::F_MOV_REG_DIR, 2'h2, 3'h4);
      run(cit_pkg::F_MOV_REG_IMM, 2'h2, 3'h2);
      run(cit_pkg::F_MOV_DIR_A, 2'h2, 3'h3);
      run(cit_pkg::F_MOV_DIR_REG, 2'h2, 3'h3);
      run(cit_pkg::F_MOV_DIR_IND, 2'h2, 3'h4);
      run(cit_pkg::F_MOV_DIR_IMM, 2'h3, 3'h3);
      run(cit_pkg::F_MOV_IND_A, 2'h1, 3'h3);
      run(cit_pkg::F_MOV_IND_DIR, 2'h2, 3'h3);
      run(cit_pkg::F_MOV_IND_IMM, 2'h2, 3'h3);
      $display("moves done");
   endtask

   task automatic t_alu();
      run(cit_pkg::F_ALU_REG, 2'h1, 3'h2);
      run(cit_pkg::F_ALU_IMM, 2'h2, 3'h2);
      run(cit_pkg::F_ALU_DIR, 2'h2, 3'h3);
      run(cit_pkg::F_ALU_IND, 2'h1, 3'h3);
      run(cit_pkg::F_LOGIC_DIR_A, 2'h2, 3'h4);
      run(cit_pkg::F_LOGIC_DIR_IMM, 2'h3, 3'h4);
      run(cit_pkg::F_ROT_SWAP, 2'h1, 3'h1);
      run(cit_pkg::F_CLR_A, 2'h1, 3'h1);
      run(cit_pkg::F_CPL_A, 2'h1, 3'h2);
      run(cit_pkg::F_INCDEC_A, 2'h1, 3'h2);
      run(cit_pkg::F_INCDEC_REG, 2'h1, 3'h3);
      run(cit_pkg::F_INCDEC_DIR, 2'h2, 3'h4);
      run(cit_pkg::F_INCDEC_IND, 2'h1, 3'h4);
      run(cit_pkg::F_INC_DP, 2'h1, 3'h1);
      run(cit_pkg::F_MUL, 2'h1, 3'h4);
      run(cit_pkg::F_DIV, 2'h1, 3'h5);
      run(cit_pkg::F_DEC_ADJ, 2'h1, 3'h4);
      $display("alu done");
   endtask

   task automatic t_stack_bits();
      run(cit_pkg::F_PUSH, 2'h2, 3'h4);
      run(cit_pkg::F_POP, 2'h2, 3'h3);
      run(cit_pkg::F_XCH_REG, 2'h1, 3'h3);
      run(cit_pkg::F_XCH_DIR, 2'h2, 3'h4);
      run(cit_pkg::F_XCH_IND, 2'h1, 3'h4);
      run(cit_pkg::F_LOW_DIGIT_XCH, 2'h1, 3'h4);
      run(cit_pkg::F_BIT_TO_CARRY, 2'h2, 3'h3);
      run(cit_pkg::F_CARRY_TO_BIT, 2'h2, 3'h4);
      run(cit_pkg::F_CARRY_OP, 2'h1, 3'h1);
      run(cit_pkg::F_BIT_OP, 2'h2, 3'h4);
      run(cit_pkg::F_NOP, 2'h1, 3'h1);
      $display("stack and bits done");
   endtask

   task automatic t_branch();
      go(cit_pkg::F_JMP_FLAG, 1'b0, 1'b1, 16'h00f0, 2'h2, 3'h3);
      run(cit_pkg::F_JMP_BIT, 2'h3, 3'h4);
      run(cit_pkg::F_BIT_TEST_CLR, 2'h3, 3'h5);
      run(cit_pkg::F_CALL_ABS, 2'h2, 3'h6);
      go(cit_pkg::F_CALL_LONG, 1'b0, 1'b1, 16'h0800, 2'h3, 3'h6);
      run(cit_pkg::F_RETURN, 2'h1, 3'h4);
      run(cit_pkg::F_JMP_ABS, 2'h2, 3'h3);
      run(cit_pkg::F_JMP_SHORT, 2'h2, 3'h3);
      go(cit_pkg::F_JMP_LONG, 1'b0, 1'b1, 16'h1234, 2'h3, 3'h4);
      run(cit_pkg::F_JMP_IND, 2'h1, 3'h3);
      run(cit_pkg::F_CMP_MEM, 2'h3, 3'h5);
      run(cit_pkg::F_CMP_IMM, 2'h3, 3'h4);
      run(cit_pkg::F_DEC_BR_REG, 2'h2, 3'h4);
      run(cit_pkg::F_DEC_BR_DIR, 2'h3, 3'h5);
      $display("branch done");
   endtask

   task automatic t_refused();
      go(cit_pkg::F_AUX_MOVE, 1'b1, 1'b1, 16'hbeef, 2'h1, 3'h0);
      go(cit_pkg::cit_form_e'(6'h3f), 1'b0, 1'b0, 16'h0000, 2'h1, 3'h0);
      run(cit_pkg::F_AUX_MOVE, 2'h1, 3'h3);
      $display("refused done");
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      reset_n    = 1'b0;
      req        = 1'b0;
      req_ext    = 1'b0;
      req_br     = 1'b0;
      req_tgt    = 16'h0000;
      req_form   = cit_pkg::F_NOP;
      exp_fa     = 16'h0000;
      n_errors   = 0;
      n_compared = 0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk(fetch_addr_r, 16'h0000);
      chk(16'(issue_ready_r), 16'h0001);
      t_moves();
      t_alu();
      t_stack_bits();
      t_branch();
      t_refused();
      stop_test();
   end
endmodule
`default_nettype wire
